// [rtl/spi_status_readback_mux.v]
// Serial output word selection for the high-side switch SPI port
`timescale 1ns/100ps
`include "readback_defines.vh"

// Summary of operation
// [RQ1] Each transfer returns eight bits chosen by the previous valid message.
// [RQ2] Top returned bit is the watchdog toggle bit from the prior message.
// [RQ3] Low seven bits chosen by select bits of latest status-select command.
// [RQ4] Address 000 returns the live fault flag word.
// [RQ5] Fault word order: temp, oc high, oc low, open load, uv, ov, summary.
// [RQ6] Overcurrent high and low flags are latched once set.
// [RQ7] Undervoltage flag can be latched or follow the live condition.
// [RQ8] Summary fault flag clears when the fault word is read.
// [RQ9] Error indicator clears on new switch-on via SPI or input pin.
// [RQ10] Address 001 returns current-sense enable and SPI switch-on bits.
// [RQ11] Address 010 returns overcurrent high level and low level code.
// [RQ12] Address 011 returns blanking time, timeout active, open-load active.
// [RQ13] Address 100 returns the input-control and current-ratio settings.
// [RQ14] Address 101 extended 0 returns delay setting and fail-safe output state.
// [RQ15] Address 101 extended 1 returns watchdog settings and expiry flag.
// [RQ16] Address 110 extended 0 returns input, fail-safe select, wake pins.
// [RQ17] Address 110 extended 1 returns undervoltage and overvoltage disables.
// [RQ18] Address 111 returns zeros in the low selectable bits.
// [RQ19] Word loads at chip select fall, shifts out MSB first.
// [RQ20] Only transfers of a whole multiple of eight bits take effect.
// [RQ21] Selection holds until the next status-select command.
// [RQ22] Selection resets to the null address.
module spi_status_readback_mux (
    input wire i_clock,
    input wire i_rst,
    input wire i_spi_cs_n,
    input wire i_spi_sck,
    input wire i_spi_si,
    output reg o_spi_so,
    output reg o_spi_so_oe,
    output reg [7:0] o_rx_word,
    output reg o_rx_valid,
    input wire i_in_pin,
    input wire i_failsafe_select_pin,
    input wire i_wake_pin,
    input wire i_over_temperature,
    input wire i_overcurrent_high,
    input wire i_overcurrent_low,
    input wire i_open_load,
    input wire i_undervoltage,
    input wire i_overvoltage,
    input wire i_uv_latch_mode,
    input wire i_current_sense_enable,
    input wire i_spi_switch_on,
    input wire i_oc_high_level,
    input wire [2:0] i_oc_low_level,
    input wire [1:0] i_oc_blanking,
    input wire i_oc_timeout_active,
    input wire i_open_load_active,
    input wire [3:0] i_input_control_config,
    input wire [2:0] i_switching_delay_config,
    input wire i_failsafe_output_state,
    input wire [1:0] i_watchdog_config,
    input wire i_watchdog_expired_flag,
    input wire i_uv_protect_disable,
    input wire i_ov_protect_disable,
    output reg o_error_indicator_output,
    output reg [6:0] o_fault_flag_word
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire [5:0] pins_sync;
    wire cs_n_s;
    wire sck_s;
    wire si_s;
    wire in_pin_s;
    wire fsi_pin_s;
    wire wake_pin_s;

    pin_sync #(
        .WIDTH(6)
    ) u_pin_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async({~i_spi_cs_n, i_spi_sck, i_spi_si, i_in_pin, i_failsafe_select_pin,
            i_wake_pin}),
        .o_sync(pins_sync)
    );

    assign cs_n_s = ~pins_sync[5]; // Synced inverted so reset reads as idle, no false frame
    assign sck_s = pins_sync[4];
    assign si_s = pins_sync[3];
    assign in_pin_s = pins_sync[2];
    assign fsi_pin_s = pins_sync[1];
    assign wake_pin_s = pins_sync[0];

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    reg cs_n_d_r;
    reg sck_d_r;
    reg in_pin_d_r;
    reg spi_on_d_r;

    wire cs_fall = cs_n_d_r & ~cs_n_s;
    wire cs_rise = ~cs_n_d_r & cs_n_s;
    wire framed = ~cs_n_s & ~cs_n_d_r;
    wire sck_rise = framed & ~sck_d_r & sck_s;
    wire sck_fall = framed & sck_d_r & ~sck_s;
    wire switch_on_evt = (in_pin_s & ~in_pin_d_r) | (i_spi_switch_on & ~spi_on_d_r);

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cs_n_d_r <= 1'h1;
            sck_d_r <= 1'h0;
            in_pin_d_r <= 1'h0;
            spi_on_d_r <= 1'h0;
        end else begin
            cs_n_d_r <= cs_n_s;
            sck_d_r <= sck_s;
            in_pin_d_r <= in_pin_s;
            spi_on_d_r <= i_spi_switch_on;
        end
    end

    // ------------------------------------------------------------
    // Transfer state
    // ------------------------------------------------------------
    reg [7:0] shift_r;
    reg [2:0] bit_cnt_r;
    reg any_bit_r;
    reg [3:0] select_r;
    reg wd_bit_r;
    reg fault_loaded_r;
    reg [6:0] flags_r;
    reg [6:0] low_word;

    wire valid_end = cs_rise & any_bit_r & (bit_cnt_r == `RST_COUNT);
    wire [2:0] rx_addr = shift_r[`MSG_ADDR_HI:`MSG_ADDR_LO];
    wire fault_read = valid_end & fault_loaded_r;

    // ------------------------------------------------------------
    // Fault flags
    // ------------------------------------------------------------
    wire any_fault = i_over_temperature | i_overcurrent_high | i_overcurrent_low |
        i_open_load | i_undervoltage | i_overvoltage;
    reg [6:0] flags_nxt;

    always @* begin
        flags_nxt = flags_r;
        // Live flags follow the condition
        flags_nxt[`FLT_OT] = i_over_temperature;
        flags_nxt[`FLT_OL] = i_open_load;
        flags_nxt[`FLT_OV] = i_overvoltage;
        // [RQ8] Read clears summary
        if (fault_read) begin
            flags_nxt[`FLT_SUM] = 1'h0;
            flags_nxt[`FLT_OCH] = 1'h0;
            flags_nxt[`FLT_OCL] = 1'h0;
            flags_nxt[`FLT_UV] = 1'h0;
        end
        // [RQ6] Overcurrent flags latch, set wins
        if (i_overcurrent_high) begin
            flags_nxt[`FLT_OCH] = 1'h1;
        end
        if (i_overcurrent_low) begin
            flags_nxt[`FLT_OCL] = 1'h1;
        end
        // [RQ7] Undervoltage latched or live
        if (i_uv_latch_mode) begin
            if (i_undervoltage) begin
                flags_nxt[`FLT_UV] = 1'h1;
            end
        end else begin
            flags_nxt[`FLT_UV] = i_undervoltage;
        end
        // Summary set wins over the read clear
        if (any_fault) begin
            flags_nxt[`FLT_SUM] = 1'h1;
        end
    end

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            flags_r <= `RST_FLAGS;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ------------------------------------------------------------
    // Error indicator pin
    // ------------------------------------------------------------
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_error_indicator_output <= 1'h0;
        end else if (any_fault) begin
            // Fault held over a switch-on keeps the pin set
            o_error_indicator_output <= 1'h1;
        // [RQ9] Switch-on clears indicator
        end else if (switch_on_evt) begin
            o_error_indicator_output <= 1'h0;
        end
    end

    // ------------------------------------------------------------
    // Readback word selection
    // ------------------------------------------------------------
    always @* begin
        low_word = 7'h00;
        // [RQ3] Select lower bits
        case (select_r[2:0])
            // [RQ4] Live fault word
            `RB_FAULT: begin
                // [RQ5] Fault bit order
                low_word = flags_r;
            end
            // [RQ10] Switch control bits
            `RB_SWITCH: begin
                low_word = {`RB_SWITCH, 2'h0, i_current_sense_enable, i_spi_switch_on};
            end
            // [RQ11] Overcurrent levels
            `RB_OC_LEVEL: begin
                low_word = {`RB_OC_LEVEL, i_oc_high_level, i_oc_low_level};
            end
            // [RQ12] Overcurrent timing
            `RB_OC_TIMING: begin
                low_word = {`RB_OC_TIMING, i_open_load_active, i_oc_timeout_active,
                    i_oc_blanking};
            end
            // [RQ13] Input control settings
            `RB_INPUT_CTRL: begin
                low_word = {`RB_INPUT_CTRL, i_input_control_config};
            end
            `RB_DELAY_WDOG: begin
                if (select_r[3]) begin
                    // [RQ15] Watchdog settings
                    low_word = {`RB_DELAY_WDOG, 1'h0, i_watchdog_expired_flag,
                        i_watchdog_config};
                end else begin
                    // [RQ14] Delay and fail-safe state
                    low_word = {`RB_DELAY_WDOG, i_failsafe_output_state,
                        i_switching_delay_config};
                end
            end
            `RB_PINS_SUPPLY: begin
                if (select_r[3]) begin
                    // [RQ17] Supply protection disables
                    low_word = {`RB_PINS_SUPPLY, 2'h0, i_uv_protect_disable,
                        i_ov_protect_disable};
                end else begin
                    // [RQ16] Sampled pin levels
                    low_word = {`RB_PINS_SUPPLY, 1'h0, in_pin_s, fsi_pin_s, wake_pin_s};
                end
            end
            // [RQ18] Null address returns zeros
            `RB_NULL: begin
                low_word = 7'h00;
            end
            default: begin
                low_word = 7'h00;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            shift_r <= `RST_BYTE;
            bit_cnt_r <= `RST_COUNT;
            any_bit_r <= 1'h0;
            fault_loaded_r <= 1'h0;
            o_spi_so <= 1'h0;
            o_spi_so_oe <= 1'h0;
        end else if (cs_fall) begin
            // [RQ19] Load at chip select fall
            // [RQ1] Word chosen by previous message
            // [RQ2] Prior watchdog bit on top
            shift_r <= {wd_bit_r, low_word};
            o_spi_so <= wd_bit_r;
            o_spi_so_oe <= 1'h1;
            bit_cnt_r <= `RST_COUNT;
            any_bit_r <= 1'h0;
            fault_loaded_r <= (select_r[2:0] == `RB_FAULT);
        end else if (cs_rise) begin
            // Output released between frames
            o_spi_so_oe <= 1'h0;
        end else if (sck_rise) begin
            // [RQ19] Input bits enter at the bottom
            shift_r <= {shift_r[6:0], si_s};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            any_bit_r <= 1'h1;
        end else if (sck_fall) begin
            // [RQ19] Next bit MSB first; later bits echo input
            o_spi_so <= shift_r[7];
        end
    end

    // ------------------------------------------------------------
    // Commit of a finished message
    // ------------------------------------------------------------
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            // [RQ22] Null selection after reset
            select_r <= `RST_SELECT;
            wd_bit_r <= `RST_WD_BIT;
            o_rx_word <= `RST_BYTE;
            o_rx_valid <= 1'h0;
        end else begin
            o_rx_valid <= 1'h0;
            // [RQ20] Only whole bytes take effect
            if (valid_end) begin
                // Daisy chains leave this device the last byte
                o_rx_word <= shift_r;
                o_rx_valid <= 1'h1;
                wd_bit_r <= shift_r[`MSG_WD_BIT];
                // [RQ21] Only status-select changes selection
                if (rx_addr == `STATUS_SELECT_ADDR) begin
                    select_r <= {shift_r[`MSG_WD_BIT], shift_r[`MSG_SEL_HI:`MSG_SEL_LO]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Fault word view
    // ------------------------------------------------------------
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_fault_flag_word <= `RST_FLAGS;
        end else begin
            o_fault_flag_word <= flags_nxt;
        end
    end

endmodule // spi_status_readback_mux

// [pkg/readback_defines.vh]
// Constants for the serial readback selector
`ifndef READBACK_DEFINES_VH
`define READBACK_DEFINES_VH

// ------------------------------------------------------------
// Message layout
// ------------------------------------------------------------
`define MSG_WIDTH 8
`define MSG_WD_BIT 7
`define MSG_ADDR_HI 6
`define MSG_ADDR_LO 4
`define MSG_SEL_HI 2
`define MSG_SEL_LO 0
`define STATUS_SELECT_ADDR 3'h0

// ------------------------------------------------------------
// Readback addresses
// ------------------------------------------------------------
`define RB_FAULT 3'h0
`define RB_SWITCH 3'h1
`define RB_OC_LEVEL 3'h2
`define RB_OC_TIMING 3'h3
`define RB_INPUT_CTRL 3'h4
`define RB_DELAY_WDOG 3'h5
`define RB_PINS_SUPPLY 3'h6
`define RB_NULL 3'h7

// ------------------------------------------------------------
// Fault word bit positions
// ------------------------------------------------------------
`define FLT_OT 6
`define FLT_OCH 5
`define FLT_OCL 4
`define FLT_OL 3
`define FLT_UV 2
`define FLT_OV 1
`define FLT_SUM 0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_SELECT 4'h7
`define RST_WD_BIT 1'h0
`define RST_FLAGS 7'h00
`define RST_BYTE 8'h00
`define RST_COUNT 3'h0

`endif

// [rtl/pin_sync.v]
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps

module pin_sync #(
    parameter WIDTH = 1
) (
    input wire i_clock,
    input wire i_rst,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    // ------------------------------------------------------------
    // Per-bit flop pair
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta_r;
            reg sync_r;
            // First stage is read only by the second
            always @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    meta_r <= 1'h0;
                    sync_r <= 1'h0;
                end else begin
                    meta_r <= i_async[g];
                    sync_r <= meta_r;
                end
            end
            assign o_sync[g] = sync_r;
        end
    endgenerate

endmodule // pin_sync

// [testbench/spi_status_readback_mux_monitor.sv]
// Port-level assertions for the serial readback selector
`timescale 1ns/100ps
module spi_status_readback_mux_monitor (
    input wire i_clock,
    input wire i_rst,
    input wire i_spi_cs_n,
    input wire i_spi_sck,
    input wire o_spi_so,
    input wire o_spi_so_oe,
    input wire o_rx_valid,
    input wire i_over_temperature,
    input wire i_overcurrent_high,
    input wire i_overcurrent_low,
    input wire i_open_load,
    input wire i_undervoltage,
    input wire i_overvoltage,
    input wire i_uv_protect_disable,
    input wire i_ov_protect_disable,
    input wire o_error_indicator_output,
    input wire [6:0] o_fault_flag_word
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // Disabled supply faults are not required to be reported
    wire any_fault = i_over_temperature | i_overcurrent_high | i_overcurrent_low | i_open_load
        | (i_undervoltage & ~i_uv_protect_disable) | (i_overvoltage & ~i_ov_protect_disable);
    logic [3:0] quiet_r;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) quiet_r <= 4'h0;
        else if ($changed(i_spi_sck) || $changed(i_spi_cs_n)) quiet_r <= 4'h0;
        else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
    end
    a_oe_on_frame: assert property ($fell(i_spi_cs_n) |-> ##[2:4] o_spi_so_oe)
        else $error("output enable late after select");
    a_oe_off_idle: assert property (i_spi_cs_n [*5] |-> !o_spi_so_oe)
        else $error("output driven while deselected");
    a_so_moves_late: assert property ($changed(o_spi_so) && o_spi_so_oe |-> quiet_r < 4'h6)
        else $error("serial output moved without clock edge");
    a_valid_one_pulse: assert property (o_rx_valid |=> !o_rx_valid)
        else $error("receive pulse too long");
    a_valid_after_frame: assert property (o_rx_valid |-> i_spi_cs_n && $past(i_spi_cs_n, 2))
        else $error("receive pulse inside frame");
    a_och_latch_hold: assert property ($fell(o_fault_flag_word[5]) |->
        (o_rx_valid || $past(o_rx_valid) || $past(o_rx_valid, 2)))
        else $error("latched flag cleared without read");
    a_ot_follows: assert property (i_over_temperature |-> ##[1:3] o_fault_flag_word[6])
        else $error("temperature flag missing");
    a_summary_set: assert property (any_fault |-> ##[1:3] o_fault_flag_word[0])
        else $error("summary flag not set");
    a_err_set: assert property (any_fault |-> ##[1:3] o_error_indicator_output)
        else $error("error indicator not set");
    a_err_clear_clean: assert property ($fell(o_error_indicator_output) |-> !$past(any_fault))
        else $error("error indicator cleared during fault");
    cover property (o_rx_valid);
    cover property ($fell(o_fault_flag_word[5]));
    cover property ($fell(o_error_indicator_output));
endmodule // spi_status_readback_mux_monitor
bind spi_status_readback_mux spi_status_readback_mux_monitor spi_status_readback_mux_monitor_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_spi_cs_n(i_spi_cs_n), .i_spi_sck(i_spi_sck),
    .o_spi_so(o_spi_so), .o_spi_so_oe(o_spi_so_oe), .o_rx_valid(o_rx_valid),
    .i_over_temperature(i_over_temperature), .i_overcurrent_high(i_overcurrent_high),
    .i_overcurrent_low(i_overcurrent_low), .i_open_load(i_open_load),
    .i_undervoltage(i_undervoltage), .i_overvoltage(i_overvoltage),
    .i_uv_protect_disable(i_uv_protect_disable), .i_ov_protect_disable(i_ov_protect_disable),
    .o_error_indicator_output(o_error_indicator_output), .o_fault_flag_word(o_fault_flag_word));

// [testbench/spi_master_model.sv]
// Behavioural SPI master standing in for the microcontroller
`timescale 1ns/100ps
module spi_master_model (
    input wire logic i_clock,
    input wire logic i_so,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si
);
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
    end
    // Whole bytes normally; other counts only on request
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge i_clock) o_cs_n = 1'b0;
        repeat (6) @(negedge i_clock);
        for (int b = n - 1; b >= 0; b--) begin
            o_si = tx[b];
            repeat (6) @(negedge i_clock);
            rx = {rx[14:0], i_so};
            o_sck = 1'b1;
            repeat (6) @(negedge i_clock);
            o_sck = 1'b0;
        end
        repeat (6) @(negedge i_clock);
        o_cs_n = 1'b1;
        // Released line must not keep its last level
        o_si = ~o_si;
        repeat (6) @(negedge i_clock);
    endtask
endmodule // spi_master_model

// [testbench/spi_status_readback_mux_tb.sv]
// Self-checking bench for the serial readback selector
`timescale 1ns/100ps
module spi_status_readback_mux_tb;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [5:0] flt = 6'h00;
    logic uv_mode = 1'b0;
    logic in_pin = 1'b0;
    logic [24:0] cfg = 25'h095A5C6;
    logic [15:0] r;
    logic [3:0] prv;
    int mismatches = 0;
    int total_checks = 0;
    wire cs_n, sck, si, so, so_oe, rx_valid, err;
    wire [7:0] o_rx_word;
    wire [6:0] ffw;
    logic [7:0] valid_cnt = 8'h00;
    // Released output shows the inverse, so a late enable corrupts reads
    wire so_line = so_oe ? so : ~so;
    initial forever #2 i_clock = ~i_clock;
    // Pulse stands a full cycle, so one falling edge sees it
    always @(negedge i_clock) if (rx_valid === 1'b1) valid_cnt <= valid_cnt + 8'h01;
    spi_master_model spi_master_model_i (.i_clock(i_clock), .i_so(so_line), .o_cs_n(cs_n),
        .o_sck(sck), .o_si(si));
    spi_status_readback_mux spi_status_readback_mux_i (.i_clock(i_clock), .i_rst(i_rst),
        .i_spi_cs_n(cs_n), .i_spi_sck(sck), .i_spi_si(si), .o_spi_so(so), .o_spi_so_oe(so_oe),
        .o_rx_word(o_rx_word), .o_rx_valid(rx_valid), .i_in_pin(in_pin),
        .i_failsafe_select_pin(cfg[23]), .i_wake_pin(cfg[24]), .i_over_temperature(flt[5]),
        .i_overcurrent_high(flt[4]), .i_overcurrent_low(flt[3]), .i_open_load(flt[2]),
        .i_undervoltage(flt[1]), .i_overvoltage(flt[0]), .i_uv_latch_mode(uv_mode),
        .i_current_sense_enable(cfg[0]), .i_spi_switch_on(cfg[1]), .i_oc_high_level(cfg[2]),
        .i_oc_low_level(cfg[5:3]), .i_oc_blanking(cfg[7:6]), .i_oc_timeout_active(cfg[8]),
        .i_open_load_active(cfg[9]), .i_input_control_config(cfg[13:10]),
        .i_switching_delay_config(cfg[16:14]), .i_failsafe_output_state(cfg[17]),
        .i_watchdog_config(cfg[19:18]), .i_watchdog_expired_flag(cfg[20]),
        .i_uv_protect_disable(cfg[21]), .i_ov_protect_disable(cfg[22]),
        .o_error_indicator_output(err), .o_fault_flag_word(ffw));
    function automatic logic [7:0] ev(input logic [3:0] s, input logic w);
        logic [6:0] l;
        case (s[2:0])
            3'h1: l = {5'h04, cfg[0], cfg[1]};
            3'h2: l = {3'h2, cfg[2], cfg[5:3]};
            3'h3: l = {3'h3, cfg[9], cfg[8], cfg[7:6]};
            3'h4: l = {3'h4, cfg[13:10]};
            3'h5: l = s[3] ? {4'hA, cfg[20], cfg[19:18]} : {3'h5, cfg[17], cfg[16:14]};
            3'h6: l = s[3] ? {5'h18, cfg[21], cfg[22]} : {4'hC, in_pin, cfg[23], cfg[24]};
            default: l = 7'h00;
        endcase
        return {w, l};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tx8(input logic [7:0] d, input logic [7:0] e);
        spi_master_model_i.xfer({8'h00, d}, 8, r);
        chk(r[7:0], e);
        chk(o_rx_word, d);
    endtask
    task automatic pulse(input logic [5:0] f);
        @(negedge i_clock) flt = f;
        @(negedge i_clock) flt = 6'h00;
        repeat (4) @(negedge i_clock);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge i_clock);
        mismatches++;
        $display("ERROR %0t run timed out", $time);
        finish_test();
    end
    initial begin
        repeat (12) @(negedge i_clock);
        i_rst = 1'b0;
        repeat (5) @(negedge i_clock);
        tx8(8'h00, 8'h00);
        pulse(6'h30);
        chk({1'b0, ffw}, 8'h21);
        chk({7'h00, err}, 8'h01);
        tx8(8'h00, 8'h21);
        tx8(8'h00, 8'h00);
        uv_mode = 1'b1;
        pulse(6'h02);
        tx8(8'h00, 8'h05);
        uv_mode = 1'b0;
        pulse(6'h02);
        tx8(8'h00, 8'h01);
        @(negedge i_clock) in_pin = 1'b1;
        repeat (10) @(negedge i_clock);
        chk({7'h00, err}, 8'h00);
        $display("test faults done");
        prv = 4'h0;
        for (int p = 0; p < 2; p++) begin
            @(negedge i_clock) cfg = p ? 25'h16A5A39 : 25'h095A5C6;
            for (int i = 0; i < 16; i++) begin
                tx8({i[3], 4'h0, i[2:0]}, ev(prv, 1'b0));
                prv = i[3:0];
                tx8(8'h60, ev(prv, prv[3]));
            end
        end
        $display("test select done");
        spi_master_model_i.xfer(16'h0001, 5, r);
        chk(o_rx_word, 8'h60);
        tx8(8'h60, ev(prv, 1'b0));
        spi_master_model_i.xfer(16'h6012, 16, r);
        chk(r[7:0], 8'h60);
        chk(r[15:8], ev(prv, 1'b0));
        chk(o_rx_word, 8'h12);
        chk(valid_cnt, 8'h47);
        $display("test frame done");
        finish_test();
    end
endmodule // spi_status_readback_mux_tb
